// File: hdl/nv_xfer_pkg.sv
// Constants shared by the EEPROM transfer controller and its testbench.
// Assumes a 12-bit byte-wide register space behind the serial control port.
package nv_xfer_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [11:0] OFS_STATUS_PIN_CFG = 12'h0232;
    localparam logic [11:0] OFS_COMMIT = 12'h0234;
    localparam logic [11:0] OFS_SEG_FIRST = 12'h0A00;
    localparam logic [11:0] OFS_SEG_LAST = 12'h0A16;
    localparam logic [11:0] OFS_XFER_STATUS = 12'h0B00;
    localparam logic [11:0] OFS_ERROR = 12'h0B01;
    localparam logic [11:0] OFS_CONTROL_FIRST = 12'h0B02;
    localparam logic [11:0] OFS_STORE_TRIGGER = 12'h0B03;
    // Field positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_ERROR = 0;
    localparam int BIT_WRITE_EN = 0;
    localparam int BIT_SOFT_LOAD = 1;
    localparam int BIT_STORE = 0;
    localparam int BIT_PIN_SEL = 4;
    localparam int BIT_COMMIT = 0;
    // Segment list layout and opcodes
    localparam int SEG_COUNT = 23;
    localparam int SEG_IDX_W = 5;
    localparam int SEG_OP_BIT = 7;
    localparam logic [7:0] OP_COMMIT = 8'h80;
    localparam logic [7:0] OP_END = 8'hFF;
    localparam logic [7:0] SEG_DEF_COUNT = 8'h7F;
    localparam logic [7:0] SEG_DEF_ADDR_HI = 8'h00;
    localparam logic [7:0] SEG_DEF_ADDR_LO = 8'h00;
    // Reset value, default array depth and sequencer states
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int NV_DEPTH_DEF = 256;
    typedef enum logic [2:0] {
        S_IDLE, S_SEG, S_REQ, S_WAIT, S_MOVE, S_CHK_REQ, S_CHK, S_DONE
    } xfer_state_t;
endpackage

// File: hdl/nv_mem_if.sv
// Port bundle between the transfer controller and the nonvolatile array.
// Assumes both ends run on the same clock; read data lag a read by one cycle.
`timescale 1ns/10ps
interface nv_mem_if #(parameter int AW = 8);
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic we;
    logic re;
    modport ctrl (output addr, output wdata, output we, output re, input rdata);
    modport mem (input addr, input wdata, input we, input re, output rdata);
endinterface

// File: hdl/nv_array.sv
// Byte-wide nonvolatile storage model with registered read data.
// Assumes the controller never reads and writes in the same cycle.
`timescale 1ns/10ps
module nv_array #(
    parameter int DEPTH = 256 // Bytes held
) (
    input wire logic sys_clk, // System clock
    input wire logic ce, // Clock enable
    nv_mem_if.mem port // Controller side
);
    logic [7:0] cells [DEPTH];

    // Contents survive srst on purpose: that is what makes them nonvolatile
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            if (port.we) begin
                cells[port.addr] <= port.wdata;
            end
            if (port.re) begin
                port.rdata <= cells[port.addr];
            end
        end
    end
endmodule

// File: hdl/nv_xfer_ctrl.sv
// EEPROM transfer controller: control/status registers, segment-list walker,
// store and reload sequencer with checksum, commit strobe and status pin.
// Assumes a same-clock register port and a buffer bank with one-cycle read.
`timescale 1ns/10ps
module nv_xfer_ctrl
    import nv_xfer_pkg::*;
#(
    parameter int NV_DEPTH = nv_xfer_pkg::NV_DEPTH_DEF // EEPROM bytes
) (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic srst, // Sync reset, high
    input wire logic ce, // Clock enable
    input wire logic [nv_xfer_pkg::ADDR_W-1:0] reg_addr, // Register address
    input wire logic [nv_xfer_pkg::DATA_W-1:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    output logic [nv_xfer_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle
    input wire logic nv_boot_select_pin, // Boot select pin, async
    output logic status_out_zero_pin, // Status pin zero
    output logic commit_buffer_strobe, // Buffer to active pulse
    output logic soft_reset_pulse, // Soft reset start pulse
    output logic [nv_xfer_pkg::ADDR_W-1:0] buf_addr, // Buffer bank address
    output logic buf_rd, // Buffer read strobe
    output logic buf_wr, // Buffer write strobe
    output logic [nv_xfer_pkg::DATA_W-1:0] buf_wdata, // Buffer write data
    input wire logic [nv_xfer_pkg::DATA_W-1:0] buf_rdata // Buffer data, cycle after read
);
    import nv_xfer_pkg::*;
    localparam int NW = $clog2(NV_DEPTH);

    nv_mem_if #(.AW(NW)) mem_bus ();
    nv_array #(.DEPTH(NV_DEPTH)) u_array (
        .sys_clk(sys_clk),
        .ce(ce),
        .port(mem_bus.mem)
    );

    xfer_state_t state_r;
    logic [7:0] seg_r [SEG_COUNT];
    logic [SEG_IDX_W-1:0] seg_ptr_r;
    logic [6:0] cnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [NW-1:0] nv_ptr_r;
    logic [7:0] sum_r;
    logic busy_r, err_r, wen_r, soft_r, store_r, pin_sel_r, commit_r, soft_pulse_r;
    logic boot_meta_r, boot_sync_r;
    logic [7:0] rdata_r;
    logic [ADDR_W-1:0] buf_addr_r;
    logic buf_rd_r, buf_wr_r;
    logic [7:0] buf_wdata_r;
    logic pin_r;

    // Register decode
    wire idle = (state_r == S_IDLE);
    wire wr_store = reg_wr && reg_addr == OFS_STORE_TRIGGER && reg_wdata[BIT_STORE];
    wire wr_ctrl = reg_wr && reg_addr == OFS_CONTROL_FIRST;
    wire wr_soft = wr_ctrl && reg_wdata[BIT_SOFT_LOAD];
    wire wr_commit = reg_wr && reg_addr == OFS_COMMIT && reg_wdata[BIT_COMMIT];
    wire in_seg = reg_addr >= OFS_SEG_FIRST && reg_addr <= OFS_SEG_LAST;
    wire [SEG_IDX_W-1:0] seg_idx = SEG_IDX_W'(reg_addr - OFS_SEG_FIRST);
    // Write protection gates a store request before it can start
    wire start_store = idle && wr_store && wen_r;
    wire start_load = idle && wr_soft && !boot_sync_r;
    wire start_any = start_store || start_load;

    // Segment walker view; a pointer past the list ends the transfer safely
    wire seg_end = (32'(seg_ptr_r) >= SEG_COUNT);
    wire [7:0] seg_b0 = seg_end ? OP_END : seg_r[seg_ptr_r];
    wire [7:0] seg_b1 = (32'(seg_ptr_r) + 1 < SEG_COUNT) ? seg_r[seg_ptr_r + 5'd1] : RST_BYTE;
    wire [7:0] seg_b2 = (32'(seg_ptr_r) + 2 < SEG_COUNT) ? seg_r[seg_ptr_r + 5'd2] : RST_BYTE;
    wire seg_is_op = seg_b0[SEG_OP_BIT];
    wire seg_commit = (state_r == S_SEG) && seg_b0 == OP_COMMIT;

    // Array port, driven combinationally by the sequencer
    assign mem_bus.addr = nv_ptr_r;
    assign mem_bus.we = store_r && wen_r && ((state_r == S_MOVE) || (state_r == S_CHK_REQ));
    assign mem_bus.wdata = (state_r == S_MOVE) ? buf_rdata : sum_r;
    assign mem_bus.re = !store_r && ((state_r == S_WAIT) || (state_r == S_CHK_REQ));
    wire [7:0] moved = store_r ? buf_rdata : mem_bus.rdata;

    // Readback mux; reserved bits and unmapped offsets read zero
    wire [7:0] rd_mux =
        (reg_addr == OFS_XFER_STATUS) ? 8'(busy_r) << BIT_BUSY :
        (reg_addr == OFS_ERROR) ? 8'(err_r) << BIT_ERROR :
        (reg_addr == OFS_CONTROL_FIRST) ?
            ((8'(soft_r) << BIT_SOFT_LOAD) | (8'(wen_r) << BIT_WRITE_EN)) :
        (reg_addr == OFS_STORE_TRIGGER) ? 8'(store_r) << BIT_STORE :
        (reg_addr == OFS_STATUS_PIN_CFG) ? 8'(pin_sel_r) << BIT_PIN_SEL :
        in_seg ? seg_r[seg_idx] : RST_BYTE;

    // Boot select pin crosses in through two flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            boot_meta_r <= 1'b1;
            boot_sync_r <= 1'b1;
        end else if (ce) begin
            boot_meta_r <= nv_boot_select_pin;
            boot_sync_r <= boot_meta_r;
        end
    end

    // Host-writable control bits; enable resets to protected
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wen_r <= 1'b0;
            pin_sel_r <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                wen_r <= reg_wdata[BIT_WRITE_EN];
            end
            if (reg_wr && reg_addr == OFS_STATUS_PIN_CFG) begin
                pin_sel_r <= reg_wdata[BIT_PIN_SEL];
            end
        end
    end

    // Segment list; default moves 128 bytes from 0x000, commits, then ends
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < SEG_COUNT; i++) begin
                seg_r[i] <= (i == 0) ? SEG_DEF_COUNT : (i == 1) ? SEG_DEF_ADDR_HI :
                    (i == 2) ? SEG_DEF_ADDR_LO : (i == 3) ? OP_COMMIT : OP_END;
            end
        end else if (ce && reg_wr && in_seg && idle) begin
            seg_r[seg_idx] <= reg_wdata; // List is frozen while it is being walked
        end
    end

    // Register read data and output flops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_r <= RST_BYTE;
            pin_r <= 1'b0;
            commit_r <= 1'b0;
            soft_pulse_r <= 1'b0;
        end else if (ce) begin
            rdata_r <= reg_rd ? rd_mux : rdata_r;
            pin_r <= pin_sel_r && busy_r;
            commit_r <= wr_commit || seg_commit; // One cycle, self clearing
            soft_pulse_r <= start_load;
        end
    end

    // Transfer sequencer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= S_IDLE;
            busy_r <= 1'b0;
            err_r <= 1'b0;
            store_r <= 1'b0;
            soft_r <= 1'b0;
            seg_ptr_r <= '0;
            cnt_r <= '0;
            addr_r <= '0;
            nv_ptr_r <= '0;
            sum_r <= RST_BYTE;
            buf_addr_r <= '0;
            buf_rd_r <= 1'b0;
            buf_wr_r <= 1'b0;
            buf_wdata_r <= RST_BYTE;
        end else if (ce) begin
            buf_rd_r <= 1'b0;
            buf_wr_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (start_any) begin
                        state_r <= S_SEG;
                        busy_r <= 1'b1;
                        err_r <= 1'b0;
                        store_r <= start_store;
                        soft_r <= start_load;
                        seg_ptr_r <= '0;
                        nv_ptr_r <= '0;
                        sum_r <= RST_BYTE;
                    end
                end
                S_SEG: begin
                    // Opcodes take one byte, data entries three
                    if (seg_end || seg_b0 == OP_END) begin
                        state_r <= S_CHK_REQ;
                    end else if (seg_is_op) begin
                        seg_ptr_r <= seg_ptr_r + 5'd1;
                    end else begin
                        cnt_r <= seg_b0[6:0];
                        addr_r <= {seg_b1[3:0], seg_b2};
                        seg_ptr_r <= seg_ptr_r + 5'd3;
                        state_r <= S_REQ;
                    end
                end
                S_REQ: begin
                    buf_addr_r <= addr_r;
                    buf_rd_r <= store_r;
                    state_r <= S_WAIT;
                end
                S_WAIT: begin
                    state_r <= S_MOVE;
                end
                S_MOVE: begin
                    buf_wr_r <= !store_r;
                    buf_wdata_r <= moved;
                    sum_r <= sum_r + moved;
                    nv_ptr_r <= nv_ptr_r + 1'b1;
                    addr_r <= addr_r + 1'b1;
                    cnt_r <= cnt_r - 7'd1;
                    state_r <= (cnt_r == 7'd0) ? S_SEG : S_REQ;
                end
                S_CHK_REQ: begin
                    state_r <= store_r ? S_DONE : S_CHK;
                end
                S_CHK: begin
                    err_r <= (mem_bus.rdata != sum_r);
                    state_r <= S_DONE;
                end
                S_DONE: begin
                    busy_r <= 1'b0;
                    store_r <= 1'b0;
                    soft_r <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign status_out_zero_pin = pin_r;
    assign commit_buffer_strobe = commit_r;
    assign soft_reset_pulse = soft_pulse_r;
    assign buf_addr = buf_addr_r;
    assign buf_rd = buf_rd_r;
    assign buf_wr = buf_wr_r;
    assign buf_wdata = buf_wdata_r;

    property p_busy_read;
        @(posedge sys_clk) disable iff (srst || !ce)
        reg_rd && reg_addr == OFS_XFER_STATUS |=> reg_rdata[BIT_BUSY] == $past(busy_r);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy readback wrong");

    property p_pin;
        @(posedge sys_clk) disable iff (srst || !ce)
        pin_sel_r && busy_r |=> status_out_zero_pin;
    endproperty
    a_pin: assert property (p_pin) else $error("status pin not showing busy");

    property p_err_read;
        @(posedge sys_clk) disable iff (srst || !ce)
        reg_rd && reg_addr == OFS_ERROR |=> reg_rdata == {7'b0, $past(err_r)};
    endproperty
    a_err_read: assert property (p_err_read) else $error("error readback wrong");

    property p_soft;
        @(posedge sys_clk) disable iff (srst || !ce)
        idle && wr_soft && !boot_sync_r |=> busy_r && soft_r && soft_reset_pulse;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reload did not start");

    property p_wen_reset;
        @(posedge sys_clk) disable iff (srst)
        $past(srst) |-> !wen_r;
    endproperty
    a_wen_reset: assert property (p_wen_reset) else $error("write enable not cleared");

    property p_store_clear;
        @(posedge sys_clk) disable iff (srst || !ce)
        $fell(busy_r) |-> !store_r && !soft_r;
    endproperty
    a_store_clear: assert property (p_store_clear) else $error("trigger not cleared");

    property p_seg_commit;
        @(posedge sys_clk) disable iff (srst || !ce)
        state_r == S_SEG && seg_b0 == OP_COMMIT |=> commit_buffer_strobe;
    endproperty
    a_seg_commit: assert property (p_seg_commit) else $error("segment commit lost");

    property p_commit_pulse;
        @(posedge sys_clk) disable iff (srst || !ce)
        idle && wr_commit |=> commit_buffer_strobe ##1 !commit_buffer_strobe;
    endproperty
    a_commit_pulse: assert property (p_commit_pulse) else $error("commit not one pulse");

    property p_protect;
        @(posedge sys_clk) disable iff (srst || !ce)
        idle && wr_store && !wen_r && !start_load |=> !busy_r;
    endproperty
    a_protect: assert property (p_protect) else $error("store ran while protected");
endmodule

// File: dv/buf_bank_model.sv
// Behavioural buffer register bank on the far side of the transfer controller.
// Assumes the controller's clock; read data are valid only in the cycle after buf_rd.
`timescale 1ns/10ps
module buf_bank_model (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic ce, // Clock enable
    input wire logic [11:0] buf_addr, // Byte address
    input wire logic buf_rd, // Read strobe
    input wire logic buf_wr, // Write strobe
    input wire logic [7:0] buf_wdata, // Write data
    output logic [7:0] buf_rdata = 8'h00 // Read data
);
    logic [7:0] mem [0:4095];

    // Outside the valid cycle the data toggle, so a sample one cycle late sees the inverted byte
    always @(posedge sys_clk) begin
        if (ce) begin
            if (buf_wr) begin
                mem[buf_addr] <= buf_wdata;
            end
            buf_rdata <= buf_rd ? mem[buf_addr] : ~buf_rdata;
        end
    end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the EEPROM transfer controller.
// Assumes a small array depth and a host that drives 1 ns after each rising edge.
`timescale 1ns/10ps
module testbench;
    import nv_xfer_pkg::*;
    localparam int DEPTH = 16; // Short image keeps the run brief
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [11:0] reg_addr = 12'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nv_boot_select_pin = 1'b1;
    logic [7:0] reg_rdata, buf_wdata, buf_rdata;
    logic [11:0] buf_addr;
    logic status_out_zero_pin, commit_buffer_strobe, soft_reset_pulse, buf_rd, buf_wr;
    int mismatches = 0;
    int checks_done = 0;
    int n_soft, n_commit, n_brd, n_bwr, n_pin;

    nv_xfer_ctrl #(.NV_DEPTH(DEPTH)) uut (.sys_clk(sys_clk), .srst(srst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .nv_boot_select_pin(nv_boot_select_pin),
        .status_out_zero_pin(status_out_zero_pin),
        .commit_buffer_strobe(commit_buffer_strobe), .soft_reset_pulse(soft_reset_pulse),
        .buf_addr(buf_addr), .buf_rd(buf_rd), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
        .buf_rdata(buf_rdata));
    buf_bank_model bank (.sys_clk(sys_clk), .ce(ce), .buf_addr(buf_addr), .buf_rd(buf_rd),
        .buf_wr(buf_wr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Event counters on the design's pulse outputs
    always @(posedge sys_clk) begin
        if (!srst) begin
            n_soft += int'(soft_reset_pulse === 1'b1);
            n_commit += int'(commit_buffer_strobe === 1'b1);
            n_brd += int'(buf_rd === 1'b1);
            n_bwr += int'(buf_wr === 1'b1);
            n_pin += int'(status_out_zero_pin === 1'b1);
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic clr();
        n_soft = 0;
        n_commit = 0;
        n_brd = 0;
        n_bwr = 0;
        n_pin = 0;
    endtask
    // Bus cycles start one idle edge late so a strobe never rises in the step it fell
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic chk_rd(input string what, input logic [11:0] a, input logic [7:0] exp);
        tick(1);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        check(what, exp, reg_rdata);
    endtask
    // Polls the busy flag under a bound; a stuck flag ends the run
    task automatic wait_idle();
        int i;
        for (i = 0; i < 400; i++) begin
            tick(1);
            reg_addr = OFS_XFER_STATUS;
            reg_rd = 1'b1;
            tick(1);
            reg_rd = 1'b0;
            if (reg_rdata[BIT_BUSY] === 1'b0) break;
        end
        if (i == 400) begin
            mismatches++;
            $display("[ERR] busy flag expected 0 seen 1");
            end_sim();
        end
    endtask

    task automatic t_reset();
        chk_rd("busy", OFS_XFER_STATUS, 8'h00);
        chk_rd("error", OFS_ERROR, 8'h00);
        chk_rd("control", OFS_CONTROL_FIRST, 8'h00);
        chk_rd("store", OFS_STORE_TRIGGER, 8'h00);
        chk_rd("unmapped", 12'h0FFF, 8'h00);
        chk_rd("segment count", OFS_SEG_FIRST, SEG_DEF_COUNT);
        chk_rd("segment opcode", OFS_SEG_FIRST + 12'h0003, OP_COMMIT);
        $display("test reset_values done");
    endtask
    task automatic t_protected();
        clr();
        wr(OFS_STORE_TRIGGER, 8'h01);
        chk_rd("busy", OFS_XFER_STATUS, 8'h00);
        check("buffer reads", 8'h00, 8'(n_brd));
        $display("test protected_store done");
    endtask
    // Four bytes at 0x010, then commit, then end of list
    task automatic t_store();
        wr(OFS_SEG_FIRST, 8'h03);
        wr(OFS_SEG_FIRST + 12'h0001, 8'h00);
        wr(OFS_SEG_FIRST + 12'h0002, 8'h10);
        wr(OFS_SEG_FIRST + 12'h0003, OP_COMMIT);
        wr(OFS_SEG_FIRST + 12'h0004, OP_END);
        wr(OFS_STATUS_PIN_CFG, 8'h10);
        chk_rd("pin select", OFS_STATUS_PIN_CFG, 8'h10);
        wr(OFS_CONTROL_FIRST, 8'h01);
        clr();
        wr(OFS_STORE_TRIGGER, 8'h01);
        chk_rd("store running", OFS_STORE_TRIGGER, 8'h01);
        chk_rd("busy running", OFS_XFER_STATUS, 8'h01);
        wait_idle();
        chk_rd("store done", OFS_STORE_TRIGGER, 8'h00);
        check("buffer reads", 8'h04, 8'(n_brd));
        check("pin seen busy", 8'h01, {7'h00, n_pin > 0});
        check("pin idle", 8'h01, {7'h00, status_out_zero_pin === 1'b0});
        $display("test store done");
    endtask
    task automatic t_reload();
        for (int i = 0; i < 4; i++) bank.mem[16 + i] = 8'h00;
        nv_boot_select_pin = 1'b0;
        tick(3);
        clr();
        wr(OFS_CONTROL_FIRST, 8'h03);
        chk_rd("soft running", OFS_CONTROL_FIRST, 8'h03);
        wait_idle();
        check("soft reset pulses", 8'h01, 8'(n_soft));
        check("buffer writes", 8'h04, 8'(n_bwr));
        check("commit pulses", 8'h01, 8'(n_commit));
        for (int i = 0; i < 4; i++) check("restored byte", 8'(8'h11 * (i + 1)), bank.mem[16 + i]);
        chk_rd("error", OFS_ERROR, 8'h00);
        chk_rd("control", OFS_CONTROL_FIRST, 8'h01);
        $display("test reload done");
    endtask
    task automatic t_boot_high();
        nv_boot_select_pin = 1'b1;
        tick(3);
        clr();
        wr(OFS_CONTROL_FIRST, 8'h03);
        tick(4);
        check("soft reset pulses", 8'h00, 8'(n_soft));
        chk_rd("busy", OFS_XFER_STATUS, 8'h00);
        $display("test boot_high done");
    endtask
    // A shorter list reads a data byte in place of the checksum
    task automatic t_error();
        wr(OFS_SEG_FIRST, 8'h02);
        wr(OFS_STATUS_PIN_CFG, 8'h00);
        nv_boot_select_pin = 1'b0;
        tick(3);
        clr();
        wr(OFS_CONTROL_FIRST, 8'h03);
        wait_idle();
        chk_rd("error", OFS_ERROR, 8'h01);
        check("pin deselected", 8'h00, 8'(n_pin));
        check("buffer writes", 8'h03, 8'(n_bwr));
        $display("test error done");
    endtask
    task automatic t_commit();
        // With the clock enable low a commit write must not be taken
        ce = 1'b0;
        wr(OFS_COMMIT, 8'h01);
        tick(1);
        check("frozen strobe", 8'h00, {7'h00, commit_buffer_strobe});
        ce = 1'b1;
        clr();
        wr(OFS_COMMIT, 8'h01);
        check("commit strobe", 8'h01, {7'h00, commit_buffer_strobe});
        tick(1);
        check("commit strobe", 8'h00, {7'h00, commit_buffer_strobe});
        check("commit pulses", 8'h01, 8'(n_commit));
        chk_rd("commit bit", OFS_COMMIT, 8'h00);
        $display("test commit done");
    endtask

    initial begin
        for (int i = 0; i < 4; i++) bank.mem[16 + i] = 8'(8'h11 * (i + 1));
        clr();
        tick(20);
        srst = 1'b0;
        t_reset();
        t_protected();
        t_store();
        t_reload();
        t_boot_high();
        t_error();
        t_commit();
        end_sim();
    end
endmodule
